// [src/ctr_top.sv]
// Added by the designer: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module ctr_top
	import ctr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timebase_80mhz,
	input wire logic timebase_20mhz,
	input wire logic timebase_100khz,
	input wire logic [7:0] system_trigger_line_in,
	input wire logic [5:0] programmable_function_line_in,
	input wire logic backplane_10mhz_clock,
	input wire logic backplane_star_trigger,
	input wire logic input_reference_trigger,
	input wire logic input_start_trigger,
	input wire logic input_sample_clock,
	input wire logic input_convert_clock,
	input wire logic output_sample_clock,
	output logic [3:0] programmable_function_line_out,
	output logic [3:0] programmable_function_line_oe,
	output logic [7:0] system_trigger_line_out,
	output logic [7:0] system_trigger_line_oe,
	output logic [1:0] counter_out,
	output logic [1:0] terminal_count
);
	typedef struct packed {
		logic [1:0][9:0] ctrl;
		logic [1:0][31:0] sel;
		logic [1:0][23:0] enc_sel;
		logic [1:0][31:0] delay;
		logic [1:0][31:0] width;
		logic [1:0][31:0] low;
		logic [1:0][7:0] incr;
		logic [1:0][23:0] route;
		logic [1:0] arm_cmd;
		logic [1:0] disarm_cmd;
		logic [1:0] src_q;
		logic [1:0] gate_q;
		logic [31:0] rdata;
		logic slverr;
		logic [3:0] fn_out;
		logic [3:0] fn_oe;
		logic [7:0] trig_out;
		logic [7:0] trig_oe;
	} ctr_top_state_type;

	ctr_top_state_type st;
	ctr_top_state_type next_st;
	logic [1:0] sel_src;
	logic [1:0] sel_gate;
	logic [1:0] sel_aux;
	logic [1:0] sel_a;
	logic [1:0] sel_b;
	logic [1:0] sel_z;
	logic [1:0] sel_arm;
	logic [1:0][31:0] core_count;
	logic [1:0][31:0] core_saved;
	logic [1:0] core_armed;
	logic [1:0] core_busy;
	logic [1:0] core_tc;
	logic [1:0] core_out;
	logic unit;
	logic [5:0] offset;
	logic addr_ok;

	// trigger lines at codes 0..7, function lines at 8..13
	function automatic logic sel_common(input logic [4:0] code, input logic [7:0] trig, input logic [5:0] fn);
		logic [4:0] fidx;
		fidx = code - SEL_FN_BASE;
		if (code < SEL_FN_BASE) begin
			return trig[code[2:0]];
		end else if (code < SEL_COMMON_END) begin
			return fn[fidx[2:0]];
		end else begin
			return 1'b0;
		end
	endfunction : sel_common

	function automatic logic reg_valid(input logic [5:0] ofs);
		return ofs == CTR_REG_CTRL || ofs == CTR_REG_SEL || ofs == CTR_REG_ENC_SEL || ofs == CTR_REG_DELAY
			|| ofs == CTR_REG_WIDTH || ofs == CTR_REG_LOW || ofs == CTR_REG_INCR || ofs == CTR_REG_CMD_STATUS
			|| ofs == CTR_REG_COUNT || ofs == CTR_REG_SAVE || ofs == CTR_REG_ROUTE;
	endfunction : reg_valid

	assign unit = paddr[CTR_UNIT_BIT];
	assign offset = paddr[5:0];
	assign addr_ok = (paddr[11:7] == 5'h00) && reg_valid(offset);

	// input selectors; cross-counter terms use registered copies
	always_comb begin
		for (int i = 0; i < CTR_NUM; i++) begin
			logic [4:0] cs;
			logic [4:0] cg;
			logic [4:0] ca;
			logic [4:0] cr;
			logic [4:0] ce;
			int o;
			o = 1 - i;
			cs = st.sel[i][SEL_SRC_LSB +: 5];
			cg = st.sel[i][SEL_GATE_LSB +: 5];
			ca = st.sel[i][SEL_AUX_LSB +: 5];
			cr = st.sel[i][SEL_ARM_LSB +: 5];
			// source
			if (cs == SRC_TB80) begin
				sel_src[i] = timebase_80mhz;
			end else if (cs == SRC_TB20) begin
				sel_src[i] = timebase_20mhz;
			end else if (cs == SRC_TB100K) begin
				sel_src[i] = timebase_100khz;
			end else if (cs < SRC_CLK10) begin
				sel_src[i] = sel_common(cs - SRC_COMMON_OFS, system_trigger_line_in, programmable_function_line_in);
			end else if (cs == SRC_CLK10) begin
				sel_src[i] = backplane_10mhz_clock;
			end else if (cs == SRC_STAR) begin
				sel_src[i] = backplane_star_trigger;
			end else if (cs == SRC_OTHER_TC) begin
				sel_src[i] = core_tc[o];
			end else if (cs == SRC_OTHER_GATE) begin
				sel_src[i] = st.gate_q[o];
			end else begin
				sel_src[i] = 1'b0;
			end
			// gate
			if (cg < SEL_COMMON_END) begin
				sel_gate[i] = sel_common(cg, system_trigger_line_in, programmable_function_line_in);
			end else if (cg == GATE_REF) begin
				sel_gate[i] = input_reference_trigger;
			end else if (cg == GATE_START) begin
				sel_gate[i] = input_start_trigger;
			end else if (cg == GATE_SAMPLE) begin
				sel_gate[i] = input_sample_clock;
			end else if (cg == GATE_CONVERT) begin
				sel_gate[i] = input_convert_clock;
			end else if (cg == GATE_AO_SAMPLE) begin
				sel_gate[i] = output_sample_clock;
			end else if (cg == GATE_STAR) begin
				sel_gate[i] = backplane_star_trigger;
			end else if (cg == GATE_OTHER_OUT) begin
				sel_gate[i] = core_out[o];
			end else if (cg == GATE_OTHER_SRC) begin
				sel_gate[i] = st.src_q[o];
			end else begin
				sel_gate[i] = 1'b0;
			end
			// first edge
			if (ca < SEL_COMMON_END) begin
				sel_aux[i] = sel_common(ca, system_trigger_line_in, programmable_function_line_in);
			end else if (ca == AUX_REF) begin
				sel_aux[i] = input_reference_trigger;
			end else if (ca == AUX_START) begin
				sel_aux[i] = input_start_trigger;
			end else if (ca == AUX_STAR) begin
				sel_aux[i] = backplane_star_trigger;
			end else if (ca == AUX_OTHER_OUT) begin
				sel_aux[i] = core_out[o];
			end else if (ca == AUX_OTHER_GATE) begin
				sel_aux[i] = st.gate_q[o];
			end else if (ca == AUX_OTHER_SRC) begin
				sel_aux[i] = st.src_q[o];
			end else if (ca == AUX_OWN_GATE) begin
				sel_aux[i] = sel_gate[i];
			end else begin
				sel_aux[i] = 1'b0;
			end
			// hardware arm
			if (cr < SEL_COMMON_END) begin
				sel_arm[i] = sel_common(cr, system_trigger_line_in, programmable_function_line_in);
			end else if (cr == ARM_REF) begin
				sel_arm[i] = input_reference_trigger;
			end else if (cr == ARM_START) begin
				sel_arm[i] = input_start_trigger;
			end else if (cr == ARM_STAR) begin
				sel_arm[i] = backplane_star_trigger;
			end else if (cr == ARM_OTHER_OUT) begin
				sel_arm[i] = core_out[o];
			end else begin
				sel_arm[i] = 1'b0;
			end
			// encoder phases and index
			ce = {1'b0, st.enc_sel[i][ENC_A_LSB +: 4]};
			sel_a[i] = (ce == ENC_STAR) ? backplane_star_trigger
				: sel_common(ce, system_trigger_line_in, programmable_function_line_in);
			ce = {1'b0, st.enc_sel[i][ENC_B_LSB +: 4]};
			sel_b[i] = (ce == ENC_STAR) ? backplane_star_trigger
				: sel_common(ce, system_trigger_line_in, programmable_function_line_in);
			ce = {1'b0, st.enc_sel[i][ENC_Z_LSB +: 4]};
			sel_z[i] = (ce == ENC_STAR) ? backplane_star_trigger
				: sel_common(ce, system_trigger_line_in, programmable_function_line_in);
		end
	end

	genvar g;
	generate
		for (g = 0; g < CTR_NUM; g++) begin : gen_counter
			ctr_core u_core (
				.pclk(pclk),
				.presetn(presetn),
				.ctrl(st.ctrl[g]),
				.delay(st.delay[g]),
				.width(st.width[g]),
				.low(st.low[g]),
				.incr(st.incr[g]),
				.arm_cmd(st.arm_cmd[g]),
				.disarm_cmd(st.disarm_cmd[g]),
				.src(sel_src[g]),
				.gate(sel_gate[g]),
				.aux(sel_aux[g]),
				.phase_a(sel_a[g]),
				.phase_b(sel_b[g]),
				.index(sel_z[g]),
				.hardware_arm_input(sel_arm[g]),
				.count(core_count[g]),
				.saved(core_saved[g]),
				.armed(core_armed[g]),
				.busy(core_busy[g]),
				.terminal_count(core_tc[g]),
				.out(core_out[g])
			);
		end
	endgenerate

	// register file, output routing
	always_comb begin
		next_st = st;
		next_st.arm_cmd = 2'b00;
		next_st.disarm_cmd = 2'b00;
		next_st.src_q = sel_src;
		next_st.gate_q = sel_gate;
		if (psel && !penable) begin
			next_st.slverr = ~addr_ok;
			next_st.rdata = 32'h00000000;
			if (addr_ok) begin
				if (offset == CTR_REG_CTRL) begin
					next_st.rdata = {22'h000000, st.ctrl[unit]};
				end else if (offset == CTR_REG_SEL) begin
					next_st.rdata = st.sel[unit];
				end else if (offset == CTR_REG_ENC_SEL) begin
					next_st.rdata = {8'h00, st.enc_sel[unit]};
				end else if (offset == CTR_REG_DELAY) begin
					next_st.rdata = st.delay[unit];
				end else if (offset == CTR_REG_WIDTH) begin
					next_st.rdata = st.width[unit];
				end else if (offset == CTR_REG_LOW) begin
					next_st.rdata = st.low[unit];
				end else if (offset == CTR_REG_INCR) begin
					next_st.rdata = {24'h000000, st.incr[unit]};
				end else if (offset == CTR_REG_CMD_STATUS) begin
					next_st.rdata = {30'h00000000, core_busy[unit], core_armed[unit]};
				end else if (offset == CTR_REG_COUNT) begin
					next_st.rdata = core_count[unit];
				end else if (offset == CTR_REG_SAVE) begin
					next_st.rdata = core_saved[unit];
				end else begin
					next_st.rdata = {8'h00, st.route[unit]};
				end
			end
		end
		if (psel && penable && pwrite && addr_ok) begin
			if (offset == CTR_REG_CTRL) begin
				next_st.ctrl[unit] = pwdata[9:0];
			end else if (offset == CTR_REG_SEL) begin
				next_st.sel[unit] = pwdata;
			end else if (offset == CTR_REG_ENC_SEL) begin
				next_st.enc_sel[unit] = pwdata[23:0];
			end else if (offset == CTR_REG_DELAY) begin
				next_st.delay[unit] = pwdata;
			end else if (offset == CTR_REG_WIDTH) begin
				next_st.width[unit] = pwdata;
			end else if (offset == CTR_REG_LOW) begin
				next_st.low[unit] = pwdata;
			end else if (offset == CTR_REG_INCR) begin
				next_st.incr[unit] = pwdata[7:0];
			end else if (offset == CTR_REG_CMD_STATUS) begin
				next_st.arm_cmd[unit] = pwdata[CMD_ARM];
				next_st.disarm_cmd[unit] = pwdata[CMD_DISARM];
			end else if (offset == CTR_REG_ROUTE) begin
				next_st.route[unit] = pwdata[23:0];
			end
		end
		next_st.fn_out = 4'h0;
		next_st.fn_oe = 4'h0;
		next_st.trig_out = 8'h00;
		next_st.trig_oe = 8'h00;
		for (int i = 0; i < CTR_NUM; i++) begin
			logic [3:0] sfn;
			logic [7:0] str;
			logic [3:0] gfn;
			logic [7:0] gtr;
			sfn = st.route[i][ROUTE_SRC_FN_LSB +: 4];
			str = st.route[i][ROUTE_SRC_TRIG_LSB +: 8];
			gfn = st.route[i][ROUTE_GATE_FN_LSB +: 4];
			gtr = st.route[i][ROUTE_GATE_TRIG_LSB +: 8];
			next_st.fn_oe = next_st.fn_oe | sfn | gfn;
			next_st.trig_oe = next_st.trig_oe | str | gtr;
			next_st.fn_out = next_st.fn_out | (sfn & {4{sel_src[i]}}) | (gfn & {4{sel_gate[i]}});
			next_st.trig_out = next_st.trig_out | (str & {8{sel_src[i]}}) | (gtr & {8{sel_gate[i]}});
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.rdata;
	assign pready = 1'b1;
	assign pslverr = st.slverr & psel & penable;
	assign programmable_function_line_out = st.fn_out;
	assign programmable_function_line_oe = st.fn_oe;
	assign system_trigger_line_out = st.trig_out;
	assign system_trigger_line_oe = st.trig_oe;
	assign counter_out = core_out;
	assign terminal_count = core_tc;
endmodule : ctr_top
`default_nettype wire

// [src/ctr_pkg.sv]
// Contract
// - each counter holds an independent 32-bit count
// - equivalent-time mode: delayed pulse per gate edge
// - delay increment programmable from 0 to 255
// - gate edges ignored while pulse in progress
// - equivalent-time pulses repeat until disarmed
// - frequency division is continuous pulse train
// - count steps on chosen source edge
// - source is timebase or measured input by mode
// - source selector offers timebases, triggers, lines, backplane
// - source selector takes other counter's terminal count or gate
// - source routable to lines; lines high-impedance at start
// - gate selector offers triggers, lines, clocks, other counter
// - gate routable to function or trigger lines
// - first-edge input starts edge-separation measurement
// - first-edge selector offers listed and cross signals
// - phase B sets up/down count direction
// - phase A, B, index each have selectors
// - nothing runs until armed; then count or wait
// - arm by software or selected hardware arm
// - output pulses or toggles on terminal count
// - output polarity selectable in both modes
package ctr_pkg;
	localparam int CTR_NUM = 2;
	localparam int CTR_COUNT_WIDTH = 32;
	localparam int CTR_INCR_WIDTH = 8;
	localparam logic [31:0] CTR_COUNT_MAX = 32'hFFFFFFFF;

	// per-counter register offsets, counter select on address bit 6
	localparam logic [5:0] CTR_REG_CTRL = 6'h00;
	localparam logic [5:0] CTR_REG_SEL = 6'h04;
	localparam logic [5:0] CTR_REG_ENC_SEL = 6'h08;
	localparam logic [5:0] CTR_REG_DELAY = 6'h0C;
	localparam logic [5:0] CTR_REG_WIDTH = 6'h10;
	localparam logic [5:0] CTR_REG_LOW = 6'h14;
	localparam logic [5:0] CTR_REG_INCR = 6'h18;
	localparam logic [5:0] CTR_REG_CMD_STATUS = 6'h1C;
	localparam logic [5:0] CTR_REG_COUNT = 6'h20;
	localparam logic [5:0] CTR_REG_SAVE = 6'h24;
	localparam logic [5:0] CTR_REG_ROUTE = 6'h28;
	localparam int CTR_UNIT_BIT = 6;

	// control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_SRC_FALL = 3;
	localparam int CTRL_GATE_FALL = 4;
	localparam int CTRL_AUX_FALL = 5;
	localparam int CTRL_OUT_TOGGLE = 6;
	localparam int CTRL_OUT_INVERT = 7;
	localparam int CTRL_HARDWARE_ARM_INPUT_EN = 8;
	localparam int CTRL_UPDOWN_B = 9;
	localparam logic [9:0] CTRL_RESET = 10'h000;
	localparam int CMD_ARM = 0;
	localparam int CMD_DISARM = 1;
	localparam int STAT_ARMED = 0;
	localparam int STAT_BUSY = 1;

	// selector field positions
	localparam int SEL_SRC_LSB = 0;
	localparam int SEL_GATE_LSB = 8;
	localparam int SEL_AUX_LSB = 16;
	localparam int SEL_ARM_LSB = 24;
	localparam int ENC_A_LSB = 0;
	localparam int ENC_B_LSB = 8;
	localparam int ENC_Z_LSB = 16;
	// route fields
	localparam int ROUTE_SRC_FN_LSB = 0;
	localparam int ROUTE_SRC_TRIG_LSB = 4;
	localparam int ROUTE_GATE_FN_LSB = 12;
	localparam int ROUTE_GATE_TRIG_LSB = 16;
	localparam logic [23:0] ROUTE_RESET = 24'h000000;

	// shared select codes: 0..7 trigger lines, 8..13 function lines
	localparam logic [4:0] SEL_FN_BASE = 5'h08;
	localparam logic [4:0] SEL_COMMON_END = 5'h0E;
	localparam logic [4:0] SRC_TB80 = 5'h00;
	localparam logic [4:0] SRC_TB20 = 5'h01;
	localparam logic [4:0] SRC_TB100K = 5'h02;
	localparam logic [4:0] SRC_COMMON_OFS = 5'h03;
	localparam logic [4:0] SRC_CLK10 = 5'h11;
	localparam logic [4:0] SRC_STAR = 5'h12;
	localparam logic [4:0] SRC_OTHER_TC = 5'h13;
	localparam logic [4:0] SRC_OTHER_GATE = 5'h14;
	localparam logic [4:0] GATE_REF = 5'h0E;
	localparam logic [4:0] GATE_START = 5'h0F;
	localparam logic [4:0] GATE_SAMPLE = 5'h10;
	localparam logic [4:0] GATE_CONVERT = 5'h11;
	localparam logic [4:0] GATE_AO_SAMPLE = 5'h12;
	localparam logic [4:0] GATE_STAR = 5'h13;
	localparam logic [4:0] GATE_OTHER_OUT = 5'h14;
	localparam logic [4:0] GATE_OTHER_SRC = 5'h15;
	localparam logic [4:0] AUX_REF = 5'h0E;
	localparam logic [4:0] AUX_START = 5'h0F;
	localparam logic [4:0] AUX_STAR = 5'h10;
	localparam logic [4:0] AUX_OTHER_OUT = 5'h11;
	localparam logic [4:0] AUX_OTHER_GATE = 5'h12;
	localparam logic [4:0] AUX_OTHER_SRC = 5'h13;
	localparam logic [4:0] AUX_OWN_GATE = 5'h14;
	localparam logic [4:0] ARM_REF = 5'h0E;
	localparam logic [4:0] ARM_START = 5'h0F;
	localparam logic [4:0] ARM_STAR = 5'h10;
	localparam logic [4:0] ARM_OTHER_OUT = 5'h11;
	localparam logic [4:0] ENC_STAR = 5'h0E;

	typedef enum logic [2:0] {
		CTR_MODE_EDGE_COUNT = 3'b000,
		CTR_MODE_PULSE_TRAIN = 3'b001,
		CTR_MODE_ETS = 3'b010,
		CTR_MODE_TWO_EDGE = 3'b011,
		CTR_MODE_TWO_PULSE = 3'b100
	} ctr_mode_type;

	typedef enum logic [2:0] {
		CTR_PH_IDLE = 3'b000,
		CTR_PH_DELAY = 3'b001,
		CTR_PH_HIGH = 3'b010,
		CTR_PH_LOW = 3'b011,
		CTR_PH_COUNT = 3'b100,
		CTR_PH_DONE = 3'b101
	} ctr_phase_type;
endpackage : ctr_pkg

// [src/ctr_core.sv]
`timescale 1ns/10ps
`default_nettype none
module ctr_core
	import ctr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [9:0] ctrl,
	input wire logic [31:0] delay,
	input wire logic [31:0] width,
	input wire logic [31:0] low,
	input wire logic [7:0] incr,
	input wire logic arm_cmd,
	input wire logic disarm_cmd,
	input wire logic src,
	input wire logic gate,
	input wire logic aux,
	input wire logic phase_a,
	input wire logic phase_b,
	input wire logic index,
	input wire logic hardware_arm_input,
	output logic [31:0] count,
	output logic [31:0] saved,
	output logic armed,
	output logic busy,
	output logic terminal_count,
	output logic out
);
	typedef struct packed {
		ctr_phase_type phase;
		logic armed;
		logic [31:0] count;
		logic [31:0] cur_delay;
		logic [31:0] save;
		logic out_level;
		logic out_pin;
		logic tc;
		logic src_d;
		logic gate_d;
		logic aux_d;
		logic a_d;
		logic b_d;
		logic arm_d;
	} ctr_core_state_type;

	ctr_core_state_type st;
	ctr_core_state_type next_st;
	ctr_mode_type mode;
	logic tick;
	logic gate_e;
	logic aux_e;
	logic a_r;
	logic b_r;
	logic arm_r;
	logic up;

	assign mode = ctr_mode_type'(ctrl[CTRL_MODE_LSB +: 3]);

	always_comb begin
		next_st = st;
		next_st.tc = 1'b0;
		tick = ctrl[CTRL_SRC_FALL] ? (st.src_d & ~src) : (~st.src_d & src);
		gate_e = ctrl[CTRL_GATE_FALL] ? (st.gate_d & ~gate) : (~st.gate_d & gate);
		aux_e = ctrl[CTRL_AUX_FALL] ? (st.aux_d & ~aux) : (~st.aux_d & aux);
		a_r = ~st.a_d & phase_a;
		b_r = ~st.b_d & phase_b;
		arm_r = ~st.arm_d & hardware_arm_input;
		up = ~ctrl[CTRL_UPDOWN_B] | phase_b;
		next_st.src_d = src;
		next_st.gate_d = gate;
		next_st.aux_d = aux;
		next_st.a_d = phase_a;
		next_st.b_d = phase_b;
		next_st.arm_d = hardware_arm_input;
		if (disarm_cmd) begin
			next_st.armed = 1'b0;
			next_st.phase = CTR_PH_IDLE;
		end else if (!st.armed) begin
			if (arm_cmd || (ctrl[CTRL_HARDWARE_ARM_INPUT_EN] && arm_r)) begin
				next_st.armed = 1'b1;
				next_st.cur_delay = delay;
				next_st.out_level = 1'b0;
				next_st.count = '0;
				next_st.phase = CTR_PH_IDLE;
				if (mode == CTR_MODE_EDGE_COUNT || mode == CTR_MODE_TWO_PULSE) begin
					next_st.phase = CTR_PH_COUNT;
				end else if (mode == CTR_MODE_PULSE_TRAIN) begin
					next_st.phase = CTR_PH_DELAY;
					next_st.count = delay;
				end
			end
		end else begin
			case (mode)
				CTR_MODE_EDGE_COUNT: begin
					if (tick) begin
						next_st.count = up ? st.count + 32'h00000001 : st.count - 32'h00000001;
						next_st.tc = up ? (st.count == CTR_COUNT_MAX) : (st.count == 32'h00000000);
					end
				end
				CTR_MODE_PULSE_TRAIN: begin
					if (tick) begin
						if (st.count <= 32'h00000001) begin
							next_st.tc = 1'b1;
							next_st.phase = (st.phase == CTR_PH_HIGH) ? CTR_PH_LOW : CTR_PH_HIGH;
							next_st.count = (st.phase == CTR_PH_HIGH) ? low : width;
						end else begin
							next_st.count = st.count - 32'h00000001;
						end
					end
				end
				CTR_MODE_ETS: begin
					if (st.phase == CTR_PH_IDLE) begin
						if (gate_e) begin
							next_st.phase = CTR_PH_DELAY;
							next_st.count = st.cur_delay;
						end
					end else if (tick) begin
						if (st.count <= 32'h00000001) begin
							next_st.tc = 1'b1;
							if (st.phase == CTR_PH_DELAY) begin
								next_st.phase = CTR_PH_HIGH;
								next_st.count = width;
							end else begin
								next_st.phase = CTR_PH_IDLE;
								next_st.cur_delay = st.cur_delay + {24'h000000, incr};
							end
						end else begin
							next_st.count = st.count - 32'h00000001;
						end
					end
				end
				CTR_MODE_TWO_EDGE: begin
					if (st.phase == CTR_PH_IDLE && aux_e) begin
						next_st.phase = CTR_PH_COUNT;
						next_st.count = '0;
					end else if (st.phase == CTR_PH_COUNT) begin
						if (gate_e) begin
							next_st.save = st.count;
							next_st.tc = 1'b1;
							next_st.phase = CTR_PH_DONE;
						end else if (tick) begin
							next_st.count = st.count + 32'h00000001;
						end
					end
				end
				CTR_MODE_TWO_PULSE: begin
					if (a_r && !b_r) begin
						next_st.count = st.count + 32'h00000001;
					end else if (b_r && !a_r) begin
						next_st.count = st.count - 32'h00000001;
					end else if (index && !phase_a && !phase_b) begin
						next_st.count = '0;
					end
				end
				default: begin
					next_st.phase = CTR_PH_IDLE;
				end
			endcase
		end
		if (next_st.tc) begin
			next_st.out_level = ~st.out_level;
		end
		next_st.out_pin = ctrl[CTRL_OUT_INVERT] ^ (ctrl[CTRL_OUT_TOGGLE] ? next_st.out_level : next_st.tc);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign count = st.count;
	assign saved = st.save;
	assign armed = st.armed;
	assign busy = st.phase != CTR_PH_IDLE && st.phase != CTR_PH_DONE;
	assign terminal_count = st.tc;
	assign out = st.out_pin;
endmodule : ctr_core
`default_nettype wire

// [dv/ctr_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module ctr_checker
	import ctr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] programmable_function_line_oe,
	input wire logic [7:0] system_trigger_line_oe,
	input wire logic [1:0] terminal_count
);
	logic route_wr;
	logic arm_wr;
	logic wr_ok;
	assign wr_ok = psel && penable && pwrite && paddr[11:7] == 5'h00;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route_wr <= 1'b0;
			arm_wr <= 1'b0;
		end else begin
			route_wr <= route_wr | (wr_ok && paddr[5:0] == CTR_REG_ROUTE);
			arm_wr <= arm_wr | (wr_ok && paddr[5:0] == CTR_REG_CMD_STATUS && pwdata[CMD_ARM]);
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_acc;
		psel && penable;
	endsequence
	a_err_bad_addr: assert property (s_acc and paddr[11:7] != 5'h00 |-> pslverr)
		else $error("no error on bad address");
	a_err_good_addr: assert property (s_acc and (paddr[11:7] == 5'h00 && paddr[5:0] <= CTR_REG_ROUTE
		&& paddr[1:0] == 2'h0) |-> !pslverr) else $error("error on mapped address");
	a_err_idle: assert property (!(psel && penable) |-> !pslverr)
		else $error("error outside access");
	a_err_read_zero: assert property (s_acc and (pslverr && !pwrite) |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_ready_now: assert property ($rose(penable) |-> pready)
		else $error("wait state inserted");
	a_fn_hiz: assert property (!route_wr |-> programmable_function_line_oe == 4'h0)
		else $error("function line driven unrouted");
	a_trig_hiz: assert property (!route_wr |-> system_trigger_line_oe == 8'h00)
		else $error("trigger line driven unrouted");
	a_tc_unarmed: assert property (!arm_wr |-> terminal_count == 2'b00)
		else $error("count event while unarmed");
endmodule : ctr_checker
bind ctr_top ctr_checker chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.programmable_function_line_oe(programmable_function_line_oe),
	.system_trigger_line_oe(system_trigger_line_oe), .terminal_count(terminal_count));
`default_nettype wire

// [dv/ctr_partner.sv]
`timescale 1ns/10ps
`default_nettype none
module ctr_partner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] trig_req,
	output logic [2:0] tb,
	output logic [7:0] trig,
	output logic [12:0] misc
);
	logic [15:0] cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 16'h0;
			trig <= 8'h00;
		end else begin
			cnt <= cnt + 16'h1;
			trig <= trig_req;
		end
	end
	// free-running timebases and slow misc levels
	assign tb = {cnt[9], cnt[1], cnt[0]};
	assign misc = cnt[15:3];
endmodule : ctr_partner
`default_nettype wire

// [dv/ctr_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, x, g) begin n_tests++; if ((g) !== (x)) begin error_cnt++; $display("Error %s %h %h", n, x, g); end end
module ctr_bench
	import ctr_pkg::*;
;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} ctr_row_type;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [2:0] tb;
	logic [7:0] trig, trig_req, st_out, st_oe;
	logic [12:0] misc;
	logic [3:0] fn_out, fn_oe;
	logic [1:0] cout, tc;
	int error_cnt, n_tests, cyc, t0;
	int tcq[$];
	int g[3];
	ctr_row_type rows[11] = '{'{1'b0, 12'h000, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h028, 32'h0, 32'h0, 1'b0},
		'{1'b1, 12'h004, 32'h14151314, 32'h0, 1'b0}, '{1'b0, 12'h004, 32'h0, 32'h14151314, 1'b0},
		'{1'b1, 12'h018, 32'hFF, 32'h0, 1'b0}, '{1'b0, 12'h018, 32'h0, 32'hFF, 1'b0},
		'{1'b1, 12'h02C, 32'h1, 32'h0, 1'b1}, '{1'b0, 12'h02C, 32'h0, 32'h0, 1'b1},
		'{1'b0, 12'h080, 32'h0, 32'h0, 1'b1}, '{1'b1, 12'h020, 32'h5, 32'h0, 1'b0},
		'{1'b0, 12'h020, 32'h0, 32'h0, 1'b0}};
	ctr_partner far (.pclk(pclk), .presetn(presetn), .trig_req(trig_req), .tb(tb), .trig(trig), .misc(misc));
	ctr_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timebase_80mhz(tb[0]),
		.timebase_20mhz(tb[1]), .timebase_100khz(tb[2]), .system_trigger_line_in(trig),
		.programmable_function_line_in(misc[5:0]), .backplane_10mhz_clock(misc[6]),
		.backplane_star_trigger(misc[7]), .input_reference_trigger(misc[8]), .input_start_trigger(misc[9]),
		.input_sample_clock(misc[10]), .input_convert_clock(misc[11]), .output_sample_clock(misc[12]),
		.programmable_function_line_out(fn_out), .programmable_function_line_oe(fn_oe),
		.system_trigger_line_out(st_out), .system_trigger_line_oe(st_oe), .counter_out(cout), .terminal_count(tc));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	always @(negedge pclk) if ((tc[0] & cout[0]) === 1'b1) tcq.push_back(cyc);
	task automatic results();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		r = prdata;
		e = pslverr;
		if (i == 50) begin
			error_cnt++;
			results();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic gate();
		trig_req <= 8'h01;
		@(posedge pclk);
		trig_req <= 8'h00;
		repeat (2) @(posedge pclk);
	endtask : gate
	task automatic wt(input int n);
		int i;
		for (i = 0; i < 3000 && tcq.size() < n; i++) @(negedge pclk);
		if (i == 3000) begin
			error_cnt++;
			results();
		end
	endtask : wt
	task automatic rise();
		int i;
		for (i = 0; i < 100 && cout[1] !== 1'b0; i++) @(negedge pclk);
		for (i = 0; i < 100 && cout[1] !== 1'b1; i++) @(negedge pclk);
		if (cout[1] !== 1'b1) begin
			error_cnt++;
			results();
		end
	endtask : rise
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, trig_req} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) `CHK("rdata", rows[i].x, r)
			`CHK("pslverr", rows[i].e, e)
		end
		$display("table done");
		wr(12'h004, 32'h0);
		wr(12'h000, 32'h2);
		wr(12'h00C, 32'h3);
		wr(12'h010, 32'h2);
		wr(12'h01C, 32'h1);
		for (int k = 0; k < 3; k++) begin
			@(posedge pclk);
			if (tb[0]) @(posedge pclk);
			g[k] = cyc;
			gate();
			if (k == 1) gate();
			wt(2 * k + 2);
		end
		repeat (20) @(posedge pclk);
		`CHK("tc count", 6, tcq.size())
		`CHK("width", 4, tcq[1] - tcq[0])
		`CHK("step", 510, tcq[2] - g[1] - tcq[0] + g[0])
		`CHK("step2", 510, tcq[4] - g[2] - tcq[2] + g[1])
		wr(12'h01C, 32'h2);
		gate();
		repeat (1600) @(posedge pclk);
		`CHK("disarmed", 6, tcq.size())
		$display("delay pulse done");
		wr(12'h040, 32'hC1);
		wr(12'h04C, 32'h1);
		wr(12'h050, 32'h2);
		wr(12'h054, 32'h3);
		wr(12'h05C, 32'h1);
		rise();
		t0 = cyc;
		rise();
		`CHK("period", 10, cyc - t0)
		repeat (5) @(negedge pclk);
		`CHK("invert", 1'b1, cout[1])
		$display("pulse train done");
		wr(12'h000, 32'h0);
		wr(12'h01C, 32'h1);
		repeat (20) @(posedge pclk);
		wr(12'h01C, 32'h2);
		apb(1'b0, 12'h020, 32'h0);
		`CHK("edges", 32'h0000000B, r)
		$display("edge count done");
		wr(12'h028, 32'h10001);
		repeat (3) @(negedge pclk);
		`CHK("fn oe", 4'h1, fn_oe)
		`CHK("trig oe", 8'h01, st_oe)
		`CHK("line out", {8'h00, ~tb[0]}, {st_out, fn_out[0]})
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		`CHK("oe reset", 12'h0, {fn_oe, st_oe})
		$display("routing done");
		results();
	end
endmodule : ctr_bench
`default_nettype wire
